// >>> logic/fsc_top.sv
`timescale 1ns/1ns
// Functional notes
// [RQ1] A malformed received packet sets its error status bit and asserts the fault output.
// [RQ2] With the serial error mask set, serial errors do not assert the fault output.
// [RQ3] Serial error bits clear only on a written one; zero leaves them.
// [RQ4] With watchdog enabled, flag an error after 4 s without receive line transitions.
// [RQ5] After a start bit, a line static over 16 bit times flags a timeout.
// [RQ6] A received check code differing from the computed one flags a CRC error.
// [RQ7] Parity errors in the sync frame and payload frames are flagged separately.
// [RQ8] A frame without a high stop bit flags a stop-bit error.
// [RQ9] Thermal warning sets its flag and the fault output; switches stay untouched.
// [RQ10] Writing one clears the warning flag; a persisting warning sets it again at once.
// [RQ11] Thermal shutdown sets its flag, the fault output, and forces all switches per action bit.
// [RQ12] Switches stay frozen and fault asserted until the shutdown flag is written one.
// [RQ13] After shutdown recovery switching resumes from the state held before shutdown.
// [RQ14] Two-bit clock select picks oscillator or pin and pin direction; reset is internal, off.
// [RQ15] Software makes one device clock master and all others take the pin clock.
// [RQ16] Two-bit divider field sets the frame-rate divide ratio for either clock source.
// [RQ17] In clock output mode the pin is only pulled low, released for high.
// [RQ18] On watchdog error switches take the failsafe pattern; PWM resumes once cleared.
// [RQ19] Frames are start, eight data bits LSB first, even parity, one stop bit.
// [RQ20] Check code uses x^3+x+1 from zero over identifier, address and data bits.
// [RQ21] General serial error bit is the OR of all; fault output low while unmasked fault.
module fsc_top
  import fsc_pkg::*;
#(
  parameter int unsigned WD_CYC = 32'(WD_CYC_L)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rx_pin,
  input wire logic thermal_warning_flag_cmp,
  input wire logic thermal_shutdown_flag_cmp,
  input wire logic osc_level,
  input wire logic [5:0] dev_id_pin,
  input wire logic [5:0] pwm_sw_state,
  input wire logic [6:0] radc_status,
  input wire logic [11:0] res_code,
  output logic fault_out_n,
  output logic [5:0] sw_state,
  output logic pwm_hold,
  output logic pwm_ext_clk_sel,
  output logic [1:0] pwm_div,
  output logic clk_pin_o,
  output logic clk_pin_oe_n,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic software_go_control_en
);

  logic [9:0] sync_q;
  logic rx_s;
  logic warn_s;
  logic shdn_s;
  logic osc_s;
  logic [5:0] dev_id_s;

  fsc_sync #(.W(10), .RST_VAL(SYNC_RST)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({dev_id_pin, osc_level, thermal_shutdown_flag_cmp, thermal_warning_flag_cmp, rx_pin}),
    .q(sync_q)
  );
  assign rx_s = sync_q[0];
  assign warn_s = sync_q[1];
  assign shdn_s = sync_q[2];
  assign osc_s = sync_q[3];
  assign dev_id_s = sync_q[9:4];

  fsc_rx_state_type rx_state_r;
  logic rx_d_r;
  logic [15:0] cnt_r;
  logic [15:0] bit_len_r;
  logic [2:0] bitn_r;
  logic [7:0] sh_r;
  logic par_r;
  logic measure_r;
  logic [19:0] idle_cnt_r;
  logic [31:0] wd_cnt_r;
  logic in_pkt_r;
  logic [2:0] fidx_r;
  logic [7:0] idf_r;
  logic [7:0] adr_r;
  logic [7:0] dlo_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [12:0] wr_data_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic [12:0] gen_r;
  logic software_go_control_r;
  logic [5:0] cid_r;
  logic [12:0] wdcfg_r;
  logic [5:0] ovr_r;
  logic [5:0] grpa_r;
  logic [5:0] grpb_r;
  logic [12:0] msk_r;
  logic [5:0] msk_sw_r;
  logic [8:0] ser_err_r;
  logic thermal_warning_flag_r;
  logic thermal_shutdown_flag_r;
  logic fault_n_r;
  logic [5:0] sw_r;
  logic hold_r;
  logic ext_sel_r;
  logic [1:0] div_r;
  logic clk_o_r;
  logic clk_oe_n_r;
  logic [15:0] rd_mux;
  logic [8:0] err_set;

  function automatic logic [2:0] fsc_crc3(input logic [28:0] v, input int lo);
    logic [2:0] c;
    logic fb;
    c = 3'h0;
    for (int i = 28; i >= 0; i--) begin
      if (i >= lo) begin
        fb = c[2] ^ v[i];
        c = {c[1], c[0] ^ fb, fb};
      end
    end
    return c;
  endfunction : fsc_crc3

  wire rx_edge = rx_d_r ^ rx_s;
  wire rx_fall = rx_d_r & ~rx_s;
  wire [15:0] half = {1'b0, bit_len_r[15:1]};
  wire bit_end = (cnt_r == bit_len_r - 16'h0001);
  wire measuring = (rx_state_r == RX_START) && measure_r;
  wire [19:0] to_lim = measuring ? RX_TO_MAX_CYC : {bit_len_r, 4'h0};
  wire to_hit = in_pkt_r && (idle_cnt_r > to_lim); // see [RQ5]
  wire start_err = (rx_state_r == RX_START) && !measure_r && (cnt_r == half) && rx_s;
  wire frame_done = (rx_state_r == RX_STOP) && (cnt_r == half);
  wire perr = ^{sh_r, par_r}; // see [RQ19]
  wire stop_bad = ~rx_s;
  wire frame_bad = perr | stop_bad;
  wire is_read = idf_r[0];
  wire is_last = (fidx_r == FRM_DHI) || ((fidx_r == FRM_DLO) && is_read);
  wire [2:0] crc_calc = is_read ? fsc_crc3({idf_r, adr_r, 13'h0000}, CRC_RD_LO) :
                        fsc_crc3({idf_r, adr_r, dlo_r, sh_r[4:0]}, CRC_WR_LO); // see [RQ20]
  wire crc_bad = frame_done && (fidx_r != FRM_SYNC) && is_last && !frame_bad &&
                 (crc_calc != sh_r[7:5]); // see [RQ6]
  wire to_me = !idf_r[7] && (idf_r[6:1] == dev_id_s);
  wire to_grp = idf_r[7] && ((idf_r[6:1] == GEN_CALL_ID) || (idf_r[6:1] == cid_r));
  wire wd_hit = wdcfg_r[WD_EN_BIT] && (wd_cnt_r == WD_CYC); // see [RQ4]
  wire w1c_gen = wr_stb_r && (wr_addr_r == REG_GENERAL_FAULT_STATUS);
  wire w1c_ser = wr_stb_r && (wr_addr_r == REG_STAT_SER);
  wire ser_any = |ser_err_r; // see [RQ21]

  // Frame receiver; bit time is learnt from the start bit of each sync frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state_r <= RX_IDLE;
      rx_d_r <= 1'b1;
      cnt_r <= 16'h0000;
      bit_len_r <= BIT_LEN_RST;
      bitn_r <= 3'h0;
      sh_r <= 8'h00;
      par_r <= 1'b0;
      measure_r <= 1'b0;
    end else begin
      rx_d_r <= rx_s;
      if (to_hit) begin
        rx_state_r <= RX_IDLE;
      end else begin
        case (rx_state_r)
          RX_IDLE: begin
            if (rx_fall) begin
              cnt_r <= 16'h0001;
              measure_r <= !in_pkt_r;
              rx_state_r <= RX_START;
            end
          end
          RX_START: begin
            cnt_r <= cnt_r + 16'h0001;
            if (measure_r) begin
              if (rx_s) begin
                bit_len_r <= cnt_r;
                cnt_r <= 16'h0001;
                bitn_r <= 3'h0;
                rx_state_r <= RX_DATA;
              end
            end else if (start_err) begin
              rx_state_r <= RX_IDLE;
            end else if (bit_end) begin
              cnt_r <= 16'h0000;
              bitn_r <= 3'h0;
              rx_state_r <= RX_DATA;
            end
          end
          RX_DATA: begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == half) begin
              sh_r <= {rx_s, sh_r[7:1]}; // see [RQ19]
            end
            if (bit_end) begin
              cnt_r <= 16'h0000;
              bitn_r <= bitn_r + 3'h1;
              if (bitn_r == 3'h7) begin
                rx_state_r <= RX_PAR;
              end
            end
          end
          RX_PAR: begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == half) begin
              par_r <= rx_s;
            end
            if (bit_end) begin
              cnt_r <= 16'h0000;
              rx_state_r <= RX_STOP;
            end
          end
          RX_STOP: begin
            cnt_r <= cnt_r + 16'h0001;
            // Leave at mid stop bit so the next start edge is not missed
            if (frame_done) begin
              rx_state_r <= RX_IDLE;
            end
          end
          default: rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // Static-line counters for the in-packet timeout and the watchdog
  always_ff @(posedge ref_clk) begin
    if (rst || rx_edge || !in_pkt_r) begin
      idle_cnt_r <= 20'h00000;
    end else if (idle_cnt_r != 20'hFFFFF) begin
      idle_cnt_r <= idle_cnt_r + 20'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || rx_edge || !wdcfg_r[WD_EN_BIT]) begin
      wd_cnt_r <= 32'h00000000;
    end else if (wd_cnt_r != WD_CYC) begin
      wd_cnt_r <= wd_cnt_r + 32'h00000001; // see [RQ4]
    end
  end

  // Packet parser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_pkt_r <= 1'b0;
      fidx_r <= FRM_SYNC;
      idf_r <= 8'h00;
      adr_r <= 8'h00;
      dlo_r <= 8'h00;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 13'h0000;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      if (to_hit || start_err) begin
        in_pkt_r <= 1'b0;
      end else if ((rx_state_r == RX_IDLE) && rx_fall && !in_pkt_r) begin
        in_pkt_r <= 1'b1;
        fidx_r <= FRM_SYNC;
      end else if (frame_done) begin
        fidx_r <= fidx_r + 3'h1;
        if (frame_bad || ((fidx_r == FRM_SYNC) && (sh_r != SYNC_BYTE))) begin
          in_pkt_r <= 1'b0;
        end else begin
          case (fidx_r)
            FRM_ID: idf_r <= sh_r;
            FRM_ADDR: adr_r <= sh_r;
            FRM_DLO: begin
              if (!is_read) begin
                dlo_r <= sh_r;
              end
            end
            default: ;
          endcase
          if (is_last && (fidx_r != FRM_SYNC)) begin
            in_pkt_r <= 1'b0;
            if (!crc_bad) begin
              if (is_read && to_me) begin
                rsp_valid_r <= 1'b1;
                rsp_data_r <= rd_mux;
              end else if (!is_read && (to_me || to_grp)) begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= adr_r;
                wr_data_r <= {sh_r[4:0], dlo_r};
              end
            end
          end
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gen_r <= GEN_CFG_RST; // see [RQ14]
      software_go_control_r <= 1'b0;
      cid_r <= SW6_RST;
      wdcfg_r <= WD_CFG_RST;
      ovr_r <= SW6_RST;
      grpa_r <= SW6_RST;
      grpb_r <= SW6_RST;
      msk_r <= MSK_GEN_RST;
      msk_sw_r <= SW6_RST;
    end else if (wr_stb_r) begin
      case (wr_addr_r)
        REG_SOFTWARE_GO_CONTROL: software_go_control_r <= wr_data_r[0];
        REG_GEN_CFG: gen_r <= wr_data_r;
        REG_SER_CFG: cid_r <= wr_data_r[5:0];
        REG_WD_CFG: wdcfg_r <= {wr_data_r[WD_EN_BIT], 6'h00, wr_data_r[5:0]};
        REG_OPEN_OVR: ovr_r <= wr_data_r[5:0];
        REG_GRP_A: grpa_r <= wr_data_r[5:0];
        REG_GRP_B: grpb_r <= wr_data_r[5:0];
        REG_MSK_GEN: msk_r <= {wr_data_r[MSK_ACT_BIT], 5'h00, wr_data_r[6:0]};
        REG_MSK_SW: msk_sw_r <= wr_data_r[5:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    case (adr_r)
      REG_NOOP: rd_mux = {3'h0, REV_ID_VAL, 8'h00};
      REG_SOFTWARE_GO_CONTROL: rd_mux = {15'h0000, software_go_control_r};
      REG_GEN_CFG: rd_mux = {3'h0, gen_r};
      REG_SER_CFG: rd_mux = {10'h000, cid_r};
      REG_WD_CFG: rd_mux = {3'h0, wdcfg_r};
      REG_OPEN_OVR: rd_mux = {10'h000, ovr_r};
      REG_GRP_A: rd_mux = {10'h000, grpa_r};
      REG_GRP_B: rd_mux = {10'h000, grpb_r};
      REG_MSK_GEN: rd_mux = {3'h0, msk_r};
      REG_MSK_SW: rd_mux = {10'h000, msk_sw_r};
      REG_GENERAL_FAULT_STATUS: rd_mux = {9'h000, ser_any, 4'h0, thermal_shutdown_flag_r, thermal_warning_flag_r}; // see [RQ21]
      REG_RADC: rd_mux = {9'h000, radc_status};
      REG_RES_CODE: rd_mux = {4'h0, res_code};
      REG_STAT_SER: rd_mux = {7'h00, ser_err_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Error events; the set term wins over a same-cycle clear
  always_comb begin
    err_set = 9'h000;
    err_set[SE_WD] = wd_hit; // see [RQ4]
    err_set[SE_TO] = to_hit; // see [RQ5]
    err_set[SE_CRC] = crc_bad; // see [RQ6]
    err_set[SE_SPERR] = frame_done && (fidx_r == FRM_SYNC) && perr; // see [RQ7]
    err_set[SE_PPERR] = frame_done && (fidx_r != FRM_SYNC) && perr; // see [RQ7]
    err_set[SE_SSTOP] = frame_done && (fidx_r == FRM_SYNC) && stop_bad; // see [RQ8]
    err_set[SE_PSTOP] = frame_done && (fidx_r != FRM_SYNC) && stop_bad; // see [RQ8]
    err_set[SE_PSTART] = start_err;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ser_err_r <= SER_ERR_RST;
    end else begin
      ser_err_r <= (ser_err_r & ~(w1c_ser ? wr_data_r[8:0] : 9'h000)) | err_set; // see [RQ1] [RQ3]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thermal_warning_flag_r <= 1'b0;
      thermal_shutdown_flag_r <= 1'b0;
    end else begin
      thermal_warning_flag_r <= warn_s | (thermal_warning_flag_r & ~(w1c_gen & wr_data_r[STG_WARN_BIT])); // see [RQ9] [RQ10]
      thermal_shutdown_flag_r <= shdn_s | (thermal_shutdown_flag_r & ~(w1c_gen & wr_data_r[STG_SHDN_BIT])); // see [RQ11] [RQ12]
    end
  end

  // Fault output and switch control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_n_r <= 1'b1;
    end else begin
      fault_n_r <= ~((ser_any & ~msk_r[MSK_SER_BIT]) | (thermal_warning_flag_r & ~msk_r[MSK_WARN_BIT]) |
                     thermal_shutdown_flag_r); // see [RQ2] [RQ21] [RQ12]
    end
  end

  // The PWM engine is paused rather than reset, so it resumes where it stopped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_r <= SW6_RST;
      hold_r <= 1'b0;
    end else begin
      hold_r <= thermal_shutdown_flag_r; // see [RQ13]
      if (thermal_shutdown_flag_r) begin
        sw_r <= {6{msk_r[MSK_ACT_BIT]}}; // see [RQ11]
      end else if (ser_err_r[SE_WD]) begin
        sw_r <= wdcfg_r[5:0]; // see [RQ18]
      end else begin
        sw_r <= pwm_sw_state;
      end
    end
  end

  // PWM clock source, divider and shared clock pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_sel_r <= 1'b0;
      div_r <= 2'h0;
      clk_o_r <= 1'b0;
      clk_oe_n_r <= 1'b1;
    end else begin
      ext_sel_r <= (gen_r[1:0] == CLK_EXT_IN); // see [RQ14]
      div_r <= gen_r[GEN_DIV_LSB +: 2]; // see [RQ16]
      clk_o_r <= 1'b0;
      // Open drain: pull low for a low oscillator phase, release otherwise
      clk_oe_n_r <= ~((gen_r[1:0] == CLK_INT_OUT) && !osc_s); // see [RQ17]
    end
  end

  assign fault_out_n = fault_n_r;
  assign sw_state = sw_r;
  assign pwm_hold = hold_r;
  assign pwm_ext_clk_sel = ext_sel_r;
  assign pwm_div = div_r;
  assign clk_pin_o = clk_o_r;
  assign clk_pin_oe_n = clk_oe_n_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign software_go_control_en = software_go_control_r;

endmodule : fsc_top

// >>> logic/fsc_pkg.sv
package fsc_pkg;

  // Clock and timing
  localparam int CLK_KHZ = 250000;
  localparam int WD_TIME_MS = 4000;
  localparam longint WD_CYC_L = longint'(WD_TIME_MS) * longint'(CLK_KHZ);
  localparam int RX_TO_BITS = 16;
  localparam int BAUD_MIN_KBPS = 10;
  localparam int BIT_MAX_CYC = CLK_KHZ / BAUD_MIN_KBPS;
  localparam logic [19:0] RX_TO_MAX_CYC = 20'(RX_TO_BITS * BIT_MAX_CYC);
  localparam logic [15:0] BIT_LEN_RST = 16'(BIT_MAX_CYC);

  // Packet layout
  localparam logic [7:0] SYNC_BYTE = 8'h79;
  localparam logic [5:0] GEN_CALL_ID = 6'h3F;
  localparam logic [2:0] FRM_SYNC = 3'h0;
  localparam logic [2:0] FRM_ID = 3'h1;
  localparam logic [2:0] FRM_ADDR = 3'h2;
  localparam logic [2:0] FRM_DLO = 3'h3;
  localparam logic [2:0] FRM_DHI = 3'h4;
  localparam int CRC_RD_LO = 13;
  localparam int CRC_WR_LO = 0;

  // Register offsets
  localparam logic [7:0] REG_NOOP = 8'h00;
  localparam logic [7:0] REG_SOFTWARE_GO_CONTROL = 8'h01;
  localparam logic [7:0] REG_GEN_CFG = 8'h02;
  localparam logic [7:0] REG_SER_CFG = 8'h03;
  localparam logic [7:0] REG_WD_CFG = 8'h04;
  localparam logic [7:0] REG_OPEN_OVR = 8'h05;
  localparam logic [7:0] REG_GRP_A = 8'h06;
  localparam logic [7:0] REG_GRP_B = 8'h07;
  localparam logic [7:0] REG_MSK_GEN = 8'h08;
  localparam logic [7:0] REG_MSK_SW = 8'h09;
  localparam logic [7:0] REG_GENERAL_FAULT_STATUS = 8'h0A;
  localparam logic [7:0] REG_RADC = 8'h0B;
  localparam logic [7:0] REG_RES_CODE = 8'h0C;
  localparam logic [7:0] REG_STAT_SER = 8'h0D;

  // Field positions
  localparam int GEN_DIV_LSB = 2;
  localparam int WD_EN_BIT = 12;
  localparam int MSK_ACT_BIT = 12;
  localparam int MSK_SER_BIT = 6;
  localparam int MSK_WARN_BIT = 0;
  localparam int STG_SER_BIT = 6;
  localparam int STG_SHDN_BIT = 1;
  localparam int STG_WARN_BIT = 0;
  localparam int SE_WD = 8;
  localparam int SE_TO = 7;
  localparam int SE_CRC = 6;
  localparam int SE_SPERR = 5;
  localparam int SE_PPERR = 4;
  localparam int SE_SSTOP = 3;
  localparam int SE_PSTOP = 2;
  localparam int SE_PSTART = 1;

  // Reset values
  localparam logic [12:0] GEN_CFG_RST = 13'h0000;
  localparam logic [12:0] WD_CFG_RST = 13'h0000;
  localparam logic [12:0] MSK_GEN_RST = 13'h0000;
  localparam logic [5:0] SW6_RST = 6'h00;
  localparam logic [8:0] SER_ERR_RST = 9'h000;
  localparam logic [9:0] SYNC_RST = 10'h001;

  // Revision code, value arbitrary
  localparam logic [4:0] REV_ID_VAL = 5'h01;

  typedef enum logic [1:0] {
    CLK_INT_OFF = 2'h0,
    CLK_INT_OUT = 2'h1,
    CLK_EXT_IN = 2'h2
  } fsc_clk_sel_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PAR = 3'h2,
    RX_STOP = 3'h6
  } fsc_rx_state_type;

endpackage : fsc_pkg

// >>> logic/fsc_sync.sv
`timescale 1ns/1ns
module fsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit is accepted only once the last two stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        q[i] <= RST_VAL[i];
      end else if (s2_r[i] == s3_r[i]) begin
        q[i] <= s3_r[i];
      end
    end
  end

endmodule : fsc_sync

// >>> tb/fsc_assertions.sv
`timescale 1ns/1ns
module fsc_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic thermal_shutdown_flag_cmp,
  input wire logic fault_out_n,
  input wire logic [5:0] sw_state,
  input wire logic pwm_hold,
  input wire logic pwm_ext_clk_sel,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_n,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  logic rst_d_r;
  always_ff @(posedge ref_clk) begin
    rst_d_r <= rst;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  // Extra cycle of grace so sampled history never reaches into reset
  default disable iff (rst || rst_d_r);
  chk_reset_outputs: assert property (disable iff (1'b0)
    rst |=> fault_out_n && !pwm_hold && clk_pin_oe_n && !pwm_ext_clk_sel && sw_state == 6'h00)
    else $error("outputs not at reset level");
  chk_pin_open_drain: assert property (clk_pin_o == 1'b0)
    else $error("clock pin driven high");
  chk_ext_pin_off: assert property (
    pwm_ext_clk_sel [*4] |-> clk_pin_oe_n) else $error("pin driven in external mode");
  chk_shdn_fault: assert property (
    thermal_shutdown_flag_cmp [*8] |-> !fault_out_n && pwm_hold) else $error("shutdown not flagged");
  chk_hold_forced: assert property (
    pwm_hold [*3] |-> sw_state inside {6'h00, 6'h3F}) else $error("switches not forced");
  chk_hold_frozen: assert property (
    pwm_hold [*3] |-> $stable(sw_state) && !fault_out_n) else $error("switches moved");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response strobe too long");
  chk_rsp_stands: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("read data changed without strobe");
endmodule : fsc_assertions

bind fsc_top fsc_assertions chk_u (
  .ref_clk(ref_clk), .rst(rst), .thermal_shutdown_flag_cmp(thermal_shutdown_flag_cmp), .fault_out_n(fault_out_n),
  .sw_state(sw_state), .pwm_hold(pwm_hold), .pwm_ext_clk_sel(pwm_ext_clk_sel),
  .clk_pin_o(clk_pin_o), .clk_pin_oe_n(clk_pin_oe_n), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data)
);

// >>> tb/fsc_host_model.sv
`timescale 1ns/1ns
module fsc_host_model
  import fsc_pkg::*;
#(
  parameter int BIT = 20,
  parameter logic [5:0] ID = 6'h05
) (
  input wire logic ref_clk,
  output logic rx_pin
);
  initial begin
    rx_pin = 1'b1;
  end
  // Entered on a rising edge; leaves the line at the stop level
  task automatic frm(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] b;
    b = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_pin <= b[i];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask : frm
  function automatic logic [2:0] crc3(input logic [28:0] v, input int n);
    logic [2:0] c;
    logic fb;
    c = 3'h0;
    for (int i = 28; i > 28 - n; i--) begin
      fb = c[2] ^ v[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc3
  // err: 0 sync parity, 1 id parity, 2 sync stop, 3 id stop; a broken packet stops there
  task automatic pkt(input logic rd, input logic [7:0] a, input logic [12:0] d,
    input logic [2:0] cx, input logic [3:0] err);
    logic [7:0] idf;
    logic [2:0] c;
    idf = {1'b0, ID, rd};
    c = crc3({idf, a, d[7:0], d[12:8]}, rd ? 16 : 29) ^ cx;
    @(posedge ref_clk);
    frm(SYNC_BYTE, err[0], err[2]);
    if (!err[0] && !err[2]) begin
      frm(idf, err[1], err[3]);
      if (err == 4'h0) begin
        frm(a, 1'b0, 1'b0);
        if (!rd) begin
          frm(d[7:0], 1'b0, 1'b0);
        end
        frm(rd ? {c, 5'h00} : {c, d[12:8]}, 1'b0, 1'b0);
      end
    end
    rx_pin <= 1'b1;
    repeat (BIT) @(posedge ref_clk);
  endtask : pkt
endmodule : fsc_host_model

// >>> tb/test_fsc_top.sv
`timescale 1ns/1ns
module test_fsc_top;
  import fsc_pkg::*;
  logic ref_clk;
  logic rst = 1'b1;
  logic thermal_warning_flag_cmp = 1'b0;
  logic thermal_shutdown_flag_cmp = 1'b0;
  logic osc_level = 1'b0;
  logic [5:0] dev_id_pin = 6'h05;
  logic [5:0] pwm_sw_state = 6'h15;
  logic [6:0] radc_status = 7'h5A;
  logic [11:0] res_code = 12'hA5C;
  logic rx_pin, fault_out_n, pwm_hold, pwm_ext_clk_sel, clk_pin_o, clk_pin_oe_n;
  logic rsp_valid, software_go_control_en;
  logic [5:0] sw_state;
  logic [1:0] pwm_div;
  logic [15:0] rsp_data;
  logic [15:0] rd_val = 16'h0000;
  logic got_rsp = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  logic [2:0] cx_tab [5] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [3:0] er_tab [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int bit_tab [5] = '{SE_CRC, SE_SPERR, SE_PPERR, SE_SSTOP, SE_PSTOP};
  fsc_top #(.WD_CYC(2000)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .rx_pin(rx_pin), .thermal_warning_flag_cmp(thermal_warning_flag_cmp),
    .thermal_shutdown_flag_cmp(thermal_shutdown_flag_cmp), .osc_level(osc_level), .dev_id_pin(dev_id_pin),
    .pwm_sw_state(pwm_sw_state), .radc_status(radc_status), .res_code(res_code),
    .fault_out_n(fault_out_n), .sw_state(sw_state), .pwm_hold(pwm_hold),
    .pwm_ext_clk_sel(pwm_ext_clk_sel), .pwm_div(pwm_div), .clk_pin_o(clk_pin_o),
    .clk_pin_oe_n(clk_pin_oe_n), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .software_go_control_en(software_go_control_en)
  );
  fsc_host_model #(.BIT(20), .ID(6'h05)) host_u (.ref_clk(ref_clk), .rx_pin(rx_pin));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      rd_val <= rsp_data;
      got_rsp <= 1'b1;
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Settle on the falling edge so registered outputs are read after they land
  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : look
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    host_u.pkt(1'b0, a, d, 3'h0, 4'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    got_rsp <= 1'b0;
    host_u.pkt(1'b1, a, 13'h0000, 3'h0, 4'h0);
    for (int i = 0; i < 50 && !got_rsp; i++) @(posedge ref_clk);
    chk(nm, exp, got_rsp ? rd_val : 16'hXXXX);
  endtask : rd
  initial begin
    #380000;
    n_errors++;
    $display("[FAIL] run_time expected finish seen timeout");
    end_sim();
  end
  initial begin
    look(20);
    chk("rst_sw", 16'h0000, sw_state);
    chk("rst_oe_n", 16'h0001, clk_pin_oe_n);
    @(posedge ref_clk);
    rst <= 1'b0;
    look(8);
    rd(REG_GEN_CFG, 16'(GEN_CFG_RST), "gen_cfg");
    rd(REG_RADC, 16'(radc_status), "radc");
    rd(REG_RES_CODE, 16'(res_code), "res_code");
    rd(8'h20, 16'h0000, "unmapped");
    wr(REG_GEN_CFG, 13'h000D);
    look(8);
    chk("div", 16'h0003, pwm_div);
    chk("oe_n_low", 16'h0000, clk_pin_oe_n);
    @(posedge ref_clk);
    osc_level <= 1'b1;
    look(8);
    chk("oe_n_rel", 16'h0001, clk_pin_oe_n);
    @(posedge ref_clk);
    osc_level <= 1'b0;
    wr(REG_GEN_CFG, 13'h0006);
    look(8);
    chk("ext_sel", 16'h0001, pwm_ext_clk_sel);
    chk("oe_n_ext", 16'h0001, clk_pin_oe_n);
    chk("div", 16'h0001, pwm_div);
    for (int i = 0; i < 5; i++) begin
      host_u.pkt(1'b0, REG_SOFTWARE_GO_CONTROL, 13'h0001, cx_tab[i], er_tab[i]);
      look(4);
      chk("err_fault", 16'h0000, fault_out_n);
      rd(REG_STAT_SER, 16'h1 << bit_tab[i], "err_bit");
      rd(REG_GENERAL_FAULT_STATUS, 16'h0040, "err_or");
      wr(REG_STAT_SER, 13'h1 << bit_tab[i]);
      rd(REG_STAT_SER, 16'h0000, "err_clear");
    end
    chk("no_write", 16'h0000, software_go_control_en);
    wr(REG_SOFTWARE_GO_CONTROL, 13'h0001);
    @(posedge ref_clk);
    host_u.frm(SYNC_BYTE, 1'b0, 1'b0);
    host_u.frm(8'h0A, 1'b0, 1'b0);
    look(250);
    chk("to_early", 16'h0001, fault_out_n);
    look(150);
    chk("to_fault", 16'h0000, fault_out_n);
    rd(REG_STAT_SER, 16'h1 << SE_TO, "to_bit");
    chk("go_en", 16'h0001, software_go_control_en);
    wr(REG_MSK_GEN, 13'h0040);
    wr(REG_STAT_SER, 13'h1 << SE_TO);
    host_u.pkt(1'b0, REG_SOFTWARE_GO_CONTROL, 13'h0000, 3'h2, 4'h0);
    look(4);
    chk("masked", 16'h0001, fault_out_n);
    wr(REG_STAT_SER, 13'h0000);
    rd(REG_STAT_SER, 16'h1 << SE_CRC, "w0_keeps");
    wr(REG_STAT_SER, 13'h1FF);
    wr(REG_MSK_GEN, 13'h0000);
    @(posedge ref_clk);
    thermal_warning_flag_cmp <= 1'b1;
    look(8);
    chk("warn_fault", 16'h0000, fault_out_n);
    chk("warn_sw", 16'h0015, sw_state);
    wr(REG_GENERAL_FAULT_STATUS, 13'h0001);
    rd(REG_GENERAL_FAULT_STATUS, 16'h0001, "warn_again");
    @(posedge ref_clk);
    thermal_warning_flag_cmp <= 1'b0;
    wr(REG_GENERAL_FAULT_STATUS, 13'h0001);
    rd(REG_GENERAL_FAULT_STATUS, 16'h0000, "warn_clear");
    for (int k = 1; k >= 0; k--) begin
      wr(REG_MSK_GEN, 13'(k) << 12);
      @(posedge ref_clk);
      thermal_shutdown_flag_cmp <= 1'b1;
      look(8);
      chk("shdn_sw", k ? 16'h003F : 16'h0000, sw_state);
      wr(REG_GENERAL_FAULT_STATUS, 13'h0002);
      rd(REG_GENERAL_FAULT_STATUS, 16'h0002, "shdn_again");
      @(posedge ref_clk);
      thermal_shutdown_flag_cmp <= 1'b0;
      look(8);
      chk("shdn_frozen", k ? 16'h003F : 16'h0000, sw_state);
      chk("shdn_fault", 16'h0000, fault_out_n);
      wr(REG_GENERAL_FAULT_STATUS, 13'h0002);
      look(4);
      chk("resume_sw", 16'h0015, sw_state);
      chk("resume_hold", 16'h0000, pwm_hold);
    end
    wr(REG_WD_CFG, 13'h102A);
    look(1500);
    chk("wd_early", 16'h0015, sw_state);
    look(700);
    chk("wd_sw", 16'h002A, sw_state);
    chk("wd_fault", 16'h0000, fault_out_n);
    rd(REG_STAT_SER, 16'h1 << SE_WD, "wd_bit");
    wr(REG_WD_CFG, 13'h0000);
    wr(REG_STAT_SER, 13'h1 << SE_WD);
    look(4);
    chk("wd_resume", 16'h0015, sw_state);
    end_sim();
  end
endmodule : test_fsc_top
